// >>> verilog/gps_params.svh
`ifndef GPS_PARAMS_SVH
`define GPS_PARAMS_SVH

// Register byte offsets on the plain register port.
`define GPS_OFS_NEXT_PAGE 8'h00
`define GPS_OFS_LINK_STATE 8'h04
`define GPS_OFS_LOSS_COUNT 8'h08
`define GPS_OFS_STICKY 8'h0c
`define GPS_OFS_DEBUG 8'h10
`define GPS_OFS_LPI_CFG 8'h14
`define GPS_OFS_WAKE_COUNT 8'h18
`define GPS_OFS_LPI_STATUS 8'h1c
`define GPS_OFS_LINK_CFG 8'h20

// Field positions.
`define GPS_BIT_NP_LSB 16
`define GPS_BIT_SIG_DETECT 8
`define GPS_BIT_LINK_UP 4
`define GPS_BIT_SYNC 0
`define GPS_BIT_LINK_LOST 4
`define GPS_BIT_SYNC_LOST 0
`define GPS_BIT_CODE_LSB 12
`define GPS_BIT_CFG_RSVD 20
`define GPS_BIT_WAKE_LSB 4
`define GPS_BIT_TX_REQ 0
`define GPS_BIT_RX_FAIL 16
`define GPS_BIT_RX_SEEN 12
`define GPS_BIT_RX_QUIET 9
`define GPS_BIT_RX_IDLE 8
`define GPS_BIT_TX_SEEN 4
`define GPS_BIT_TX_QUIET 1
`define GPS_BIT_TX_IDLE 0
`define GPS_BIT_SGMII 0
`define GPS_BIT_SHORTENED_DOWNTIME_OPTION 4

// Reset values.
`define GPS_RST_CFG_RSVD 1'b1
`define GPS_RST_WAKE_LIMIT 2'h3
`define GPS_RST_SGMII 1'b1

// Timing: clock period and printed loss and wake times.
`define GPS_CLK_PS 20000
`define GPS_LOSS_NORM_PS 10000000000
`define GPS_LOSS_SGMII_PS 1600000000
`define GPS_LOSS_SHORT_PS 9770000
`define GPS_LOSS_SHORT_SG_PS 1560000
`define GPS_WAKE0_PS 10000000
`define GPS_WAKE1_PS 13000000
`define GPS_WAKE2_PS 17000000
`define GPS_WAKE3_PS 20000000
// Least times round up, longest times round down.
`define GPS_UP(t) (((t) + `GPS_CLK_PS - 1) / `GPS_CLK_PS)
`define GPS_DN(t) ((t) / `GPS_CLK_PS)
`define GPS_LOSS_NORM_CYC `GPS_UP(64'd10000000000)
`define GPS_LOSS_SGMII_CYC `GPS_UP(64'd1600000000)
`define GPS_LOSS_SHORT_CYC `GPS_UP(`GPS_LOSS_SHORT_PS)
`define GPS_LOSS_SHORT_SG_CYC `GPS_UP(`GPS_LOSS_SHORT_SG_PS)
`define GPS_WAKE0_CYC `GPS_DN(`GPS_WAKE0_PS)
`define GPS_WAKE1_CYC `GPS_DN(`GPS_WAKE1_PS)
`define GPS_WAKE2_CYC `GPS_DN(`GPS_WAKE2_PS)
`define GPS_WAKE3_CYC `GPS_DN(`GPS_WAKE3_PS)

`endif

// >>> verilog/gps_pkg.sv
package gps_pkg;
    typedef logic [7:0] gps_addr_t;
    typedef logic [31:0] gps_word_t;
    typedef logic [19:0] gps_loss_t;
    // Receive wake-up supervision states.
    typedef enum logic [1:0] {GPS_WAKE_IDLE, GPS_WAKE_WAIT, GPS_WAKE_FAIL} gps_wake_e;
endpackage

// >>> verilog/gps_regs.sv
`timescale 1ns/10ps
`include "gps_params.svh"

module gps_regs #(
    parameter int LOSS_NORM_CYC = int'(`GPS_LOSS_NORM_CYC),
    parameter int LOSS_SGMII_CYC = int'(`GPS_LOSS_SGMII_CYC)
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire gps_pkg::gps_addr_t reg_addr,
    input wire gps_pkg::gps_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output gps_pkg::gps_word_t reg_rdata,
    input wire logic [15:0] partner_next_page_word,
    input wire logic signal_detect_pin,
    input wire logic code_sync,
    input wire logic an_link_ok,
    input wire logic [1:0] transmit_code_mode,
    input wire logic rx_quiet,
    input wire logic rx_idle,
    input wire logic rx_waking,
    input wire logic tx_quiet,
    input wire logic tx_idle,
    output logic link_fail,
    output logic transmit_idle_request,
    output logic sgmii_variant_select
);
    import gps_pkg::*;

    localparam gps_loss_t SHORT_CYC = gps_loss_t'(`GPS_LOSS_SHORT_CYC);
    localparam gps_loss_t SHORT_SG_CYC = gps_loss_t'(`GPS_LOSS_SHORT_SG_CYC);
    localparam logic [9:0] WAKE0 = 10'(`GPS_WAKE0_CYC);
    localparam logic [9:0] WAKE1 = 10'(`GPS_WAKE1_CYC);
    localparam logic [9:0] WAKE2 = 10'(`GPS_WAKE2_CYC);
    localparam logic [9:0] WAKE3 = 10'(`GPS_WAKE3_CYC);

    logic sd_meta_r;
    logic sd_sync_r;
    logic [15:0] next_page_r;
    logic sig_detect_r;
    logic link_up_r;
    logic link_up_d_r;
    logic sync_r;
    logic [1:0] code_mode_r;
    logic [7:0] link_loss_counter_r;
    logic link_lost_flag_r;
    logic sync_lost_flag_r;
    logic cfg_rsvd_r;
    logic [1:0] receive_wake_limit_r;
    logic shortened_downtime_option_r;
    logic [15:0] wake_fault_counter_r;
    logic receive_wake_failed_r;
    logic receive_idle_seen_r;
    logic transmit_idle_seen_r;
    logic rx_quiet_r;
    logic rx_idle_r;
    logic tx_quiet_r;
    logic tx_idle_r;
    gps_loss_t loss_cnt_r;
    gps_loss_t loss_limit;
    logic [9:0] wake_cnt_r;
    logic [9:0] wake_limit;
    gps_wake_e wake_state_r;
    logic wake_fault;
    logic link_drop;
    gps_word_t rd_nxt;
    logic wr_sticky;
    logic wr_lpi_status;

    // The signal detect pin is asynchronous and passes two flip-flops first.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            sd_meta_r <= 1'b0;
            sd_sync_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sd_meta_r <= signal_detect_pin;
            sd_sync_r <= sd_meta_r;
        end
    end

    // Status snapshots from the coding logic.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            next_page_r <= 16'h0000;
            sig_detect_r <= 1'b0;
            link_up_r <= 1'b0;
            link_up_d_r <= 1'b0;
            sync_r <= 1'b0;
            code_mode_r <= 2'h0;
            rx_quiet_r <= 1'b0;
            rx_idle_r <= 1'b0;
            tx_quiet_r <= 1'b0;
            tx_idle_r <= 1'b0;
        end
        else if (clk_en)
        begin
            next_page_r <= partner_next_page_word;
            sig_detect_r <= sd_sync_r;
            link_up_r <= an_link_ok;
            link_up_d_r <= link_up_r;
            sync_r <= code_sync;
            code_mode_r <= transmit_code_mode;
            rx_quiet_r <= rx_quiet;
            rx_idle_r <= rx_idle;
            tx_quiet_r <= tx_quiet;
            tx_idle_r <= tx_idle;
        end
    end

    // Write decodes for the clear-on-one registers.
    assign wr_sticky = reg_wr && (reg_addr == `GPS_OFS_STICKY);
    assign wr_lpi_status = reg_wr && (reg_addr == `GPS_OFS_LPI_STATUS);
    assign link_drop = link_up_d_r && !link_up_r;

    // Configuration written by software.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cfg_rsvd_r <= `GPS_RST_CFG_RSVD;
            receive_wake_limit_r <= `GPS_RST_WAKE_LIMIT;
            transmit_idle_request <= 1'b0;
            sgmii_variant_select <= `GPS_RST_SGMII;
            shortened_downtime_option_r <= 1'b0;
        end
        else if (clk_en && reg_wr)
        begin
            if (reg_addr == `GPS_OFS_LPI_CFG)
            begin
                cfg_rsvd_r <= reg_wdata[`GPS_BIT_CFG_RSVD];
                receive_wake_limit_r <= reg_wdata[`GPS_BIT_WAKE_LSB +: 2];
                transmit_idle_request <= reg_wdata[`GPS_BIT_TX_REQ];
            end
            if (reg_addr == `GPS_OFS_LINK_CFG)
            begin
                sgmii_variant_select <= reg_wdata[`GPS_BIT_SGMII];
                shortened_downtime_option_r <= reg_wdata[`GPS_BIT_SHORTENED_DOWNTIME_OPTION];
            end
        end
    end

    // Loss limit picked by variant and shortened option.
    always_comb
    begin
        if (shortened_downtime_option_r)
            loss_limit = sgmii_variant_select ? SHORT_SG_CYC : SHORT_CYC;
        else if (sgmii_variant_select)
            loss_limit = gps_loss_t'(LOSS_SGMII_CYC);
        else
            loss_limit = gps_loss_t'(LOSS_NORM_CYC);
    end

    // Loss timer runs while detect or sync is missing and declares link down.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            loss_cnt_r <= '0;
            link_fail <= 1'b0;
        end
        else if (clk_en)
        begin
            if (sig_detect_r && sync_r)
            begin
                loss_cnt_r <= '0;
                link_fail <= 1'b0;
            end
            else if (loss_cnt_r < loss_limit)
                loss_cnt_r <= loss_cnt_r + 20'h00001;
            else
                link_fail <= 1'b1;
        end
    end

    // Link drop counter wraps; a write loads it, a drop in that cycle still counts.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            link_loss_counter_r <= 8'h00;
        else if (clk_en)
        begin
            if (reg_wr && (reg_addr == `GPS_OFS_LOSS_COUNT))
                link_loss_counter_r <= reg_wdata[7:0] + {7'h00, link_drop};
            else if (link_drop)
                link_loss_counter_r <= link_loss_counter_r + 8'h01;
        end
    end

    // Sticky flags; a new event beats a clear in the same cycle.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            link_lost_flag_r <= 1'b0;
            sync_lost_flag_r <= 1'b0;
            transmit_idle_seen_r <= 1'b0;
            receive_idle_seen_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!link_up_r)
                link_lost_flag_r <= 1'b1;
            else if (wr_sticky && reg_wdata[`GPS_BIT_LINK_LOST])
                link_lost_flag_r <= 1'b0;
            if (!sync_r)
                sync_lost_flag_r <= 1'b1;
            else if (wr_sticky && reg_wdata[`GPS_BIT_SYNC_LOST])
                sync_lost_flag_r <= 1'b0;
            if (tx_idle_r)
                transmit_idle_seen_r <= 1'b1;
            else if (wr_lpi_status && reg_wdata[`GPS_BIT_TX_SEEN])
                transmit_idle_seen_r <= 1'b0;
            if (rx_idle_r)
                receive_idle_seen_r <= 1'b1;
            else if (wr_lpi_status && reg_wdata[`GPS_BIT_RX_SEEN])
                receive_idle_seen_r <= 1'b0;
        end
    end

    // Selected maximum wake-up time.
    always_comb
    begin
        case (receive_wake_limit_r)
            2'h0: wake_limit = WAKE0;
            2'h1: wake_limit = WAKE1;
            2'h2: wake_limit = WAKE2;
            default: wake_limit = WAKE3;
        endcase
    end

    // Wake supervision: a wake-up that outlasts the limit is a fault.
    assign wake_fault = (wake_state_r == GPS_WAKE_WAIT) && rx_waking && (wake_cnt_r >= wake_limit);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            wake_state_r <= GPS_WAKE_IDLE;
            wake_cnt_r <= 10'h000;
            receive_wake_failed_r <= 1'b0;
        end
        else if (clk_en)
        begin
            case (wake_state_r)
                GPS_WAKE_IDLE:
                begin
                    wake_cnt_r <= 10'h000;
                    if (rx_waking)
                    begin
                        wake_state_r <= GPS_WAKE_WAIT;
                        receive_wake_failed_r <= 1'b0;
                    end
                end
                GPS_WAKE_WAIT:
                begin
                    wake_cnt_r <= wake_cnt_r + 10'h001;
                    if (!rx_waking)
                        wake_state_r <= GPS_WAKE_IDLE;
                    else if (wake_fault)
                    begin
                        wake_state_r <= GPS_WAKE_FAIL;
                        receive_wake_failed_r <= 1'b1;
                    end
                end
                GPS_WAKE_FAIL:
                begin
                    if (!rx_waking)
                        wake_state_r <= GPS_WAKE_IDLE;
                end
                default: wake_state_r <= GPS_WAKE_IDLE;
            endcase
        end
    end

    // Wake fault counter saturates; a write loads it, a fault then still counts.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            wake_fault_counter_r <= 16'h0000;
        else if (clk_en)
        begin
            if (reg_wr && (reg_addr == `GPS_OFS_WAKE_COUNT))
            begin
                if (wake_fault && (reg_wdata[15:0] != 16'hffff))
                    wake_fault_counter_r <= reg_wdata[15:0] + 16'h0001;
                else
                    wake_fault_counter_r <= reg_wdata[15:0];
            end
            else if (wake_fault && (wake_fault_counter_r != 16'hffff))
                wake_fault_counter_r <= wake_fault_counter_r + 16'h0001;
        end
    end

    // Read multiplexer; unmapped addresses read zero.
    always_comb
    begin
        rd_nxt = '0;
        case (reg_addr)
            `GPS_OFS_NEXT_PAGE: rd_nxt[`GPS_BIT_NP_LSB +: 16] = next_page_r;
            `GPS_OFS_LINK_STATE:
            begin
                rd_nxt[`GPS_BIT_SIG_DETECT] = sig_detect_r;
                rd_nxt[`GPS_BIT_LINK_UP] = link_up_r;
                rd_nxt[`GPS_BIT_SYNC] = sync_r;
            end
            `GPS_OFS_LOSS_COUNT: rd_nxt[7:0] = link_loss_counter_r;
            `GPS_OFS_STICKY:
            begin
                rd_nxt[`GPS_BIT_LINK_LOST] = link_lost_flag_r;
                rd_nxt[`GPS_BIT_SYNC_LOST] = sync_lost_flag_r;
            end
            `GPS_OFS_DEBUG: rd_nxt[`GPS_BIT_CODE_LSB +: 2] = code_mode_r;
            `GPS_OFS_LPI_CFG:
            begin
                rd_nxt[`GPS_BIT_CFG_RSVD] = cfg_rsvd_r;
                rd_nxt[`GPS_BIT_WAKE_LSB +: 2] = receive_wake_limit_r;
                rd_nxt[`GPS_BIT_TX_REQ] = transmit_idle_request;
            end
            `GPS_OFS_WAKE_COUNT: rd_nxt[15:0] = wake_fault_counter_r;
            `GPS_OFS_LPI_STATUS:
            begin
                rd_nxt[`GPS_BIT_RX_FAIL] = receive_wake_failed_r;
                rd_nxt[`GPS_BIT_RX_SEEN] = receive_idle_seen_r;
                rd_nxt[`GPS_BIT_RX_QUIET] = rx_quiet_r;
                rd_nxt[`GPS_BIT_RX_IDLE] = rx_idle_r;
                rd_nxt[`GPS_BIT_TX_SEEN] = transmit_idle_seen_r;
                rd_nxt[`GPS_BIT_TX_QUIET] = tx_quiet_r;
                rd_nxt[`GPS_BIT_TX_IDLE] = tx_idle_r;
            end
            `GPS_OFS_LINK_CFG:
            begin
                rd_nxt[`GPS_BIT_SGMII] = sgmii_variant_select;
                rd_nxt[`GPS_BIT_SHORTENED_DOWNTIME_OPTION] = shortened_downtime_option_r;
            end
            default: rd_nxt = '0;
        endcase
    end

    // Read data stand for the one cycle after the strobe, zero otherwise.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            reg_rdata <= '0;
        else if (clk_en)
            reg_rdata <= reg_rd ? rd_nxt : '0;
    end

    // Checks on the block's own behaviour.
    default clocking gps_cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence s_drop;
        clk_en && link_up_r ##1 clk_en && !link_up_r;
    endsequence

    sequence s_two_en;
        clk_en ##1 clk_en;
    endsequence

    property s_two_em_guard;
        clk_en && an_link_ok |=> !clk_en || link_up_r;
    endproperty

    AST_LINK_UP: assert property (s_two_em_guard) else $error("link up not mirrored");

    AST_LOSS_COUNT: assert property (s_drop ##0 !(reg_wr && reg_addr == `GPS_OFS_LOSS_COUNT)
        |=> !clk_en || link_loss_counter_r == $past(link_loss_counter_r) + 8'h01)
        else $error("link drop not counted");

    AST_LINK_LOST: assert property (clk_en && !link_up_r |=> link_lost_flag_r)
        else $error("link lost flag not set");

    AST_SYNC_LOST: assert property (clk_en && !sync_r |=> sync_lost_flag_r)
        else $error("sync lost flag not set");

    AST_LOSS_FIRE: assert property (clk_en && !link_fail && loss_cnt_r >= loss_limit
        && !(sig_detect_r && sync_r) |=> !clk_en || link_fail)
        else $error("link fail not declared");

    AST_FAIL_HELD: assert property (link_fail |-> loss_cnt_r >= loss_limit)
        else $error("link fail too early");

    AST_TX_REQ: assert property (s_two_en ##0 reg_wr && reg_addr == `GPS_OFS_LPI_CFG
        |=> transmit_idle_request == $past(reg_wdata[`GPS_BIT_TX_REQ]))
        else $error("idle request not taken");

    AST_WAKE_SAT: assert property (wake_fault_counter_r == 16'hffff && clk_en && !reg_wr
        |=> wake_fault_counter_r == 16'hffff)
        else $error("wake counter wrapped");

    AST_WAKE_FAIL: assert property (clk_en && wake_fault |=> receive_wake_failed_r)
        else $error("wake failure not flagged");

    AST_TX_SEEN: assert property (clk_en && tx_idle_r |=> transmit_idle_seen_r)
        else $error("transmit idle not latched");

    AST_RD_ZERO: assert property (clk_en && !reg_rd |=> reg_rdata == '0)
        else $error("read data outside its cycle");

endmodule // gps_regs

// >>> verification/gps_partner.sv
`timescale 1ns/10ps

module gps_partner (
    input wire logic ref_clk,
    output logic [15:0] partner_next_page_word,
    output logic signal_detect_pin,
    output logic code_sync,
    output logic an_link_ok,
    output logic [1:0] transmit_code_mode,
    output logic rx_quiet,
    output logic rx_idle,
    output logic rx_waking,
    output logic tx_quiet,
    output logic tx_idle
);
    // The far end starts with a good link, in sync and with no low-power activity.
    initial
    begin
        {partner_next_page_word, transmit_code_mode} = 18'h0;
        {signal_detect_pin, code_sync, an_link_ok} = 3'h7;
        {rx_quiet, rx_idle, rx_waking, tx_quiet, tx_idle} = 5'h0;
    end

    // Changes link health just after a clock edge.
    task automatic set_link(input logic ok, input logic sync, input logic sd);
        @(posedge ref_clk);
        an_link_ok <= ok;
        code_sync <= sync;
        signal_detect_pin <= sd;
    endtask

    // Changes page word, code mode and the four low-power levels together.
    task automatic set_misc(input logic [15:0] np, input logic [1:0] mode, input logic [3:0] lpi);
        @(posedge ref_clk);
        partner_next_page_word <= np;
        transmit_code_mode <= mode;
        {rx_quiet, rx_idle, tx_quiet, tx_idle} <= lpi;
    endtask

    // A wake attempt whose burst arrives after n cycles; a large n is a late burst.
    task automatic wake(input int n);
        @(posedge ref_clk);
        rx_waking <= 1'b1;
        repeat (n) @(posedge ref_clk);
        rx_waking <= 1'b0;
    endtask
endmodule // gps_partner

// >>> verification/gigabit_pcs_status_lpi_regs_tb.sv
`timescale 1ns/10ps
`include "gps_params.svh"

module gigabit_pcs_status_lpi_regs_tb;
    import gps_pkg::*;
    localparam int NORM = 200;
    localparam int SG = 50;
    logic ref_clk;
    logic reset;
    logic clk_en;
    gps_addr_t reg_addr;
    gps_word_t reg_wdata;
    logic reg_wr;
    logic reg_rd;
    gps_word_t reg_rdata;
    logic [15:0] partner_next_page_word;
    logic signal_detect_pin, code_sync, an_link_ok, rx_quiet, rx_idle, rx_waking;
    logic tx_quiet, tx_idle, link_fail, transmit_idle_request, sgmii_variant_select;
    logic [1:0] transmit_code_mode;
    int n_fail;
    int compares;
    int seed;
    int m_cnt;
    int m_wake;
    logic m_link_lost, m_sync_lost, m_rx_seen, m_tx_seen, m_rx_fail, m_prev_ok;

    gps_regs #(.LOSS_NORM_CYC(NORM), .LOSS_SGMII_CYC(SG)) dut_u (.ref_clk, .reset, .clk_en,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .partner_next_page_word,
        .signal_detect_pin, .code_sync, .an_link_ok, .transmit_code_mode, .rx_quiet,
        .rx_idle, .rx_waking, .tx_quiet, .tx_idle, .link_fail, .transmit_idle_request,
        .sgmii_variant_select);

    gps_partner p (.ref_clk, .partner_next_page_word, .signal_detect_pin, .code_sync,
        .an_link_ok, .transmit_code_mode, .rx_quiet, .rx_idle, .rx_waking, .tx_quiet, .tx_idle);

    // Free-running 50 MHz clock.
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle bus strobes, launched and dropped just after rising edges.
    task automatic wr(input gps_addr_t a, input gps_word_t d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rdc(input string name, input gps_addr_t a, input gps_word_t exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, reg_rdata, exp);
    endtask

    // Line changes update the model, then let the snapshots settle.
    task automatic line(input logic ok, input logic sync, input logic sd);
        p.set_link(ok, sync, sd);
        if (!ok)
            m_link_lost = 1'b1;
        if (m_prev_ok && !ok)
            m_cnt = (m_cnt + 1) % 256;
        m_prev_ok = ok;
        if (!sync)
            m_sync_lost = 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic misc(input logic [15:0] np, input logic [1:0] mode, input logic [3:0] v);
        p.set_misc(np, mode, v);
        m_rx_seen |= v[2];
        m_tx_seen |= v[0];
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic check_all();
        rdc("next_page", `GPS_OFS_NEXT_PAGE, {partner_next_page_word, 16'h0});
        rdc("link_state", `GPS_OFS_LINK_STATE,
            {23'h0, signal_detect_pin, 3'h0, an_link_ok, 3'h0, code_sync});
        rdc("sticky", `GPS_OFS_STICKY, {27'h0, m_link_lost, 3'h0, m_sync_lost});
        rdc("loss_count", `GPS_OFS_LOSS_COUNT, 32'(m_cnt));
        rdc("code_mode", `GPS_OFS_DEBUG, {18'h0, transmit_code_mode, 12'h0});
        rdc("lpi_status", `GPS_OFS_LPI_STATUS,
            {15'h0, m_rx_fail, 3'h0, m_rx_seen, 2'h0, rx_quiet, rx_idle, 3'h0, m_tx_seen, 2'h0,
            tx_quiet, tx_idle});
        rdc("wake_count", `GPS_OFS_WAKE_COUNT, 32'(m_wake));
    endtask

    // Main sequence: reset, then each group of register behaviour in turn.
    initial
    begin
        int lim;
        int i;
        logic sg;
        logic ud;
        logic [31:0] r;
        gps_addr_t ro_list[4];
        seed = 32'h01197617;
        {n_fail, compares, m_cnt, m_wake} = '0;
        {m_link_lost, m_sync_lost, m_rx_seen, m_tx_seen, m_rx_fail} = '0;
        // Link and sync snapshots leave reset low, so both sticky flags set at once.
        {m_link_lost, m_sync_lost} = 2'b11;
        m_prev_ok = 1'b1;
        ro_list = '{8'h00, 8'h04, 8'h10, 8'h24};
        {reset, clk_en, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 42'h0};
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        chk("tx_req_rst", {31'h0, transmit_idle_request}, 32'h0);
        chk("sgmii_rst", {31'h0, sgmii_variant_select}, 32'h1);
        rdc("cfg_rst", `GPS_OFS_LPI_CFG,
            {11'h0, `GPS_RST_CFG_RSVD, 14'h0, `GPS_RST_WAKE_LIMIT, 4'h0});
        rdc("link_cfg_rst", `GPS_OFS_LINK_CFG, {31'h0, `GPS_RST_SGMII});
        wr(`GPS_OFS_WAKE_COUNT, 32'h0);
        check_all();
        // Read-only and unmapped places ignore writes.
        foreach (ro_list[j])
            wr(ro_list[j], 32'hffffffff);
        check_all();
        rdc("unmapped", 8'h24, 32'h0);
        // Random status levels over every code mode, then clear the sticky idle flags.
        for (int k = 0; k < 8; k++)
        begin
            r = $random(seed);
            misc(r[15:0], k[1:0], r[19:16]);
            check_all();
        end
        wr(`GPS_OFS_LPI_STATUS, 32'h00011010);
        m_rx_seen = rx_idle;
        m_tx_seen = tx_idle;
        check_all();
        // Link drops count up from 254 and wrap; writing zero clears.
        wr(`GPS_OFS_LOSS_COUNT, 32'h000000fe);
        m_cnt = 254;
        for (int k = 0; k < 3; k++)
        begin
            line(1'b0, 1'b1, 1'b1);
            line(1'b1, 1'b1, 1'b1);
            check_all();
        end
        wr(`GPS_OFS_LOSS_COUNT, 32'h0);
        m_cnt = 0;
        // Loss timing in all four mode combinations, by sync loss and by detect loss.
        for (int c = 0; c < 4; c++)
        begin
            sg = ~c[1];
            ud = c[0];
            lim = sg ? (ud ? 78 : SG) : (ud ? 489 : NORM);
            wr(`GPS_OFS_LINK_CFG, {27'h0, ud, 3'h0, sg});
            chk("sgmii_sel", {31'h0, sgmii_variant_select}, {31'h0, sg});
            line(1'b1, c[0], ~c[0]);
            repeat (lim - 10) @(posedge ref_clk);
            chk("fail_early", {31'h0, link_fail}, 32'h0);
            i = 0;
            while (link_fail !== 1'b1 && i < 16)
            begin
                @(posedge ref_clk);
                i++;
            end
            chk("fail_late", {31'h0, link_fail}, 32'h1);
            if (link_fail !== 1'b1)
                final_report();
            line(1'b1, 1'b1, 1'b1);
            chk("fail_clear", {31'h0, link_fail}, 32'h0);
        end
        check_all();
        wr(`GPS_OFS_STICKY, 32'h00000011);
        {m_link_lost, m_sync_lost} = 2'b00;
        check_all();
        // Idle request follows its bit; a frozen clock enable drops the write.
        wr(`GPS_OFS_LPI_CFG, 32'h00100031);
        chk("tx_req_on", {31'h0, transmit_idle_request}, 32'h1);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(`GPS_OFS_LPI_CFG, 32'h00100030);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        rdc("cfg_frozen", `GPS_OFS_LPI_CFG, 32'h00100031);
        wr(`GPS_OFS_LPI_CFG, 32'h00100030);
        chk("tx_req_off", {31'h0, transmit_idle_request}, 32'h0);
        // Late and prompt wake bursts for every wake limit; counter saturates.
        wr(`GPS_OFS_WAKE_COUNT, 32'h0000fffd);
        m_wake = 65533;
        for (int k = 0; k < 4; k++)
        begin
            lim = (k == 0) ? 500 : (k == 1) ? 650 : (k == 2) ? 850 : 1000;
            wr(`GPS_OFS_LPI_CFG, 32'h00100000 | (k << 4));
            p.wake(lim + 20);
            m_wake = (m_wake < 65535) ? m_wake + 1 : 65535;
            m_rx_fail = 1'b1;
            check_all();
            p.wake(lim - 40);
            m_rx_fail = 1'b0;
            check_all();
        end
        wr(`GPS_OFS_WAKE_COUNT, 32'h0);
        m_wake = 0;
        check_all();
        final_report();
    end
endmodule // gigabit_pcs_status_lpi_regs_tb
